/* File: core/imdec_decoder.sv */
module imdec_decoder (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// internal space base load
	input wire logic base_wr,
	input wire logic [15:0] base_wdata,
	// request from internal masters
	input imdec_pkg::imdec_req_s req,
	// decoded answer
	output imdec_pkg::imdec_resp_s resp,
	output logic [15:0] internal_space_base
);

	// ----------------------------------------
	// internal map base register
	// ----------------------------------------
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			internal_space_base <= imdec_pkg::BASE_RESET;
		end else if (base_wr) begin
			internal_space_base <= base_wdata;
		end
	end

	// ----------------------------------------
	// space match and offset
	// ----------------------------------------
	logic sec_mode;
	logic in_space;
	logic [17:0] req_off;

	always_comb begin
		// only code 10 widens the space; 01 and 11 stay legacy
		sec_mode = internal_space_base[1:0] == imdec_pkg::LAYOUT_SECURE;
		if (sec_mode) begin
			// one contiguous 256K block on a 256K boundary
			in_space = req.addr[31:18] == internal_space_base[15:2];
			req_off = req.addr[17:0];
		end else begin
			// legacy 64K block
			in_space = req.addr[31:16] == internal_space_base;
			req_off = {2'b00, req.addr[15:0]};
		end
	end

	// ----------------------------------------
	// stage one
	// ----------------------------------------
	imdec_pkg::imdec_region_e lut_region;
	logic [15:0] lut_local;
	logic s1_valid;
	logic s1_in;
	logic s1_sec;
	logic s1_gap;
	logic s1_write;
	logic s1_word;
	logic [16:0] s1_sec_local;

	imdec_region_lut u_lut (
		.sys_clk(sys_clk),
		.rst(rst),
		.off(req_off[15:0]),
		.region(lut_region),
		.local_off(lut_local)
	);

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			s1_valid <= 1'b0;
			s1_in <= 1'b0;
			s1_sec <= 1'b0;
			s1_gap <= 1'b0;
			s1_write <= 1'b0;
			s1_word <= 1'b0;
			s1_sec_local <= 17'h0_0000;
		end else begin
			s1_valid <= req.valid;
			s1_in <= in_space;
			s1_sec <= req_off[17];
			// 0x10000-0x1FFFF of the wide block is not decoded
			s1_gap <= req_off[16] && !req_off[17];
			s1_write <= req.write;
			s1_word <= req.size == imdec_pkg::SIZE_WORD && req.addr[1:0] == 2'b00;
			s1_sec_local <= req_off[16:0];
		end
	end

	// ----------------------------------------
	// stage two: registered answer
	// ----------------------------------------
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			resp <= '0;
		end else begin
			resp.valid <= s1_valid;
			resp.write <= s1_write;
			resp.size_err <= 1'b0;
			if (!s1_in || s1_gap) begin
				resp.hit <= 1'b0;
				resp.region <= imdec_pkg::RG_NONE;
				resp.local_off <= 18'h0_0000;
			end else if (s1_sec) begin
				resp.hit <= 1'b1;
				resp.region <= imdec_pkg::RG_SEC;
				resp.local_off <= {1'b0, s1_sec_local};
				resp.size_err <= s1_valid && !s1_word;
			end else begin
				resp.hit <= lut_region != imdec_pkg::RG_NONE;
				resp.region <= lut_region;
				resp.local_off <= {2'b00, lut_local};
			end
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	logic past_ok;
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			past_ok <= 1'b0;
		end else begin
			past_ok <= s1_valid || past_ok || req.valid;
		end
	end

	sequence legacy_req;
		req.valid && in_space && !sec_mode;
	endsequence

	sequence sec_req;
		req.valid && in_space && sec_mode && req_off[17];
	endsequence

	legacy_hit_a: assert property (legacy_req
		##0 (req_off[15:0] <= imdec_pkg::SYS_HI)
		|-> ##2 resp.valid && resp.hit && resp.region == imdec_pkg::RG_SYS)
		else $error("legacy system offset not decoded");
	legacy_nosec_a: assert property (resp.region == imdec_pkg::RG_SEC
		|-> $past(internal_space_base[1:0], 2) == imdec_pkg::LAYOUT_SECURE)
		else $error("security region reached outside code 10");
	sec_region_a: assert property (sec_req
		|-> ##2 resp.hit && resp.region == imdec_pkg::RG_SEC)
		else $error("upper 128K not decoded to security");
	sec_size_a: assert property (sec_req
		##0 (req.size != imdec_pkg::SIZE_WORD) |-> ##2 resp.size_err)
		else $error("non-word security access not flagged");
	dpram_map_a: assert property (req.valid && in_space
		&& req_off[17:12] == 6'h02 |-> ##2 resp.region == imdec_pkg::RG_DPRAM)
		else $error("dual-port RAM offset not decoded");
	dpramx_map_a: assert property (req.valid && in_space
		&& req_off >= {2'b00, imdec_pkg::DPRAMX_LO} && req_off <= {2'b00, imdec_pkg::DPRAMX_HI}
		|-> ##2 resp.region == imdec_pkg::RG_DPRAMX)
		else $error("expanded dual-port RAM not decoded");
	eth2_mirror_a: assert property (resp.region == imdec_pkg::RG_ETH2 && past_ok
		|-> resp.local_off[15:0] == $past(req_off[15:0], 2) - imdec_pkg::ETH2_LO)
		else $error("second ethernet offset not mirrored");
	serial_map_a: assert property (req.valid && in_space && req_off[17:16] == 2'b00
		&& req_off[15:0] >= imdec_pkg::SER2_LO && req_off[15:0] <= imdec_pkg::SER3_HI
		|-> ##2 resp.region inside {imdec_pkg::RG_SER2, imdec_pkg::RG_SER3})
		else $error("serial controller range not decoded");
	usb_map_a: assert property (req.valid && in_space
		&& req_off[17:5] == 13'h0050 |-> ##2 resp.region == imdec_pkg::RG_USB)
		else $error("usb range not decoded");
	porte_map_a: assert property (req.valid && in_space && req_off == 18'h0_0ac8
		|-> ##2 resp.region == imdec_pkg::RG_PORTE && resp.local_off == 18'h0_0000)
		else $error("port E start not decoded");
	eth1_map_a: assert property (req.valid && in_space
		&& req_off[17:9] == 9'h007 |-> ##2 resp.region == imdec_pkg::RG_ETH1)
		else $error("first ethernet range not decoded");

	// ----------------------------------------
	// base load, misses and latency
	// ----------------------------------------
	base_load_a: assert property (base_wr
		|=> internal_space_base == $past(base_wdata))
		else $error("internal base not loaded");
	miss_quiet_a: assert property (!resp.hit
		|-> resp.region == imdec_pkg::RG_NONE && resp.local_off == 18'h0_0000)
		else $error("miss answer not cleared");
	resp_pulse_a: assert property (req.valid
		|-> ##2 resp.valid)
		else $error("answer not two cycles after request");
	out_space_a: assert property (req.valid
		&& internal_space_base[1:0] != imdec_pkg::LAYOUT_SECURE
		&& req.addr[31:16] != internal_space_base
		|-> ##2 !resp.hit)
		else $error("address outside legacy block decoded");
	reserved_code_a: assert property (req.valid
		&& internal_space_base[1:0] != imdec_pkg::LAYOUT_SECURE
		&& req.addr[31:16] == internal_space_base && req.addr[15:12] == 4'h2
		|-> ##2 resp.region == imdec_pkg::RG_DPRAM)
		else $error("legacy dual-port RAM lost under reserved code");
	gap_miss_a: assert property (req.valid && in_space && sec_mode
		&& req_off[17:16] == 2'b01 |-> ##2 !resp.hit)
		else $error("unused middle of wide block decoded");
	sec_local_a: assert property (sec_req
		|-> ##2 resp.local_off == $past(req_off, 2) - imdec_pkg::SEC_LO)
		else $error("security offset not relative to region start");
	sec_word_ok_a: assert property (sec_req
		##0 (req.size == imdec_pkg::SIZE_WORD && req.addr[1:0] == 2'b00)
		|-> ##2 !resp.size_err)
		else $error("aligned security word flagged");

endmodule // imdec_decoder

/* File: core/imdec_region_lut.sv */
module imdec_region_lut (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// offset in
	input wire logic [15:0] off,
	// registered decode out
	output imdec_pkg::imdec_region_e region,
	output logic [15:0] local_off
);

	// ----------------------------------------
	// low 64 Kbyte region table
	// ----------------------------------------
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			region <= imdec_pkg::RG_NONE;
			local_off <= 16'h0000;
		end else if (off <= imdec_pkg::SYS_HI) begin
			region <= imdec_pkg::RG_SYS;
			local_off <= off - imdec_pkg::SYS_LO;
		end else if (off >= imdec_pkg::USB_LO && off <= imdec_pkg::USB_HI) begin
			region <= imdec_pkg::RG_USB;
			local_off <= off - imdec_pkg::USB_LO;
		end else if (off >= imdec_pkg::SER2_LO && off <= imdec_pkg::SER2_HI) begin
			region <= imdec_pkg::RG_SER2;
			local_off <= off - imdec_pkg::SER2_LO;
		end else if (off >= imdec_pkg::SER3_LO && off <= imdec_pkg::SER3_HI) begin
			region <= imdec_pkg::RG_SER3;
			local_off <= off - imdec_pkg::SER3_LO;
		end else if (off >= imdec_pkg::PORTE_LO && off <= imdec_pkg::PORTE_HI) begin
			region <= imdec_pkg::RG_PORTE;
			local_off <= off - imdec_pkg::PORTE_LO;
		end else if (off >= imdec_pkg::CPM_LO && off <= imdec_pkg::CPM_HI) begin
			region <= imdec_pkg::RG_CPM;
			local_off <= off - imdec_pkg::CPM_LO;
		end else if (off >= imdec_pkg::ETH1_LO && off <= imdec_pkg::ETH1_HI) begin
			region <= imdec_pkg::RG_ETH1;
			local_off <= off - imdec_pkg::ETH1_LO;
		end else if (off >= imdec_pkg::ETH2_LO && off <= imdec_pkg::ETH2_HI) begin
			region <= imdec_pkg::RG_ETH2;
			// same register order as the first controller
			local_off <= off - imdec_pkg::ETH2_SHIFT - imdec_pkg::ETH1_LO;
		end else if (off >= imdec_pkg::DPRAM_LO && off <= imdec_pkg::DPRAM_HI) begin
			region <= imdec_pkg::RG_DPRAM;
			local_off <= off - imdec_pkg::DPRAM_LO;
		end else if (off >= imdec_pkg::DPRAMX_LO && off <= imdec_pkg::DPRAMX_HI) begin
			region <= imdec_pkg::RG_DPRAMX;
			local_off <= off - imdec_pkg::DPRAMX_LO;
		end else begin
			region <= imdec_pkg::RG_NONE;
			local_off <= 16'h0000;
		end
	end

endmodule // imdec_region_lut

/* File: dv/imdec_master.sv */
// requester standing in for the core and the other internal bus masters
module imdec_master (
	// clock
	input wire logic sys_clk,
	// request out
	output imdec_pkg::imdec_req_s req
);
	timeunit 1ns;
	timeprecision 1ns;

	initial req = '0;

	// one request, taken at the edge where valid is dropped again
	task automatic issue(input logic [31:0] addr, input logic [1:0] size, input logic wr);
		@(posedge sys_clk);
		req <= '{valid: 1'b1, addr: addr, write: wr, size: size};
		@(posedge sys_clk);
		req.valid <= 1'b0;
		// released lines must not keep the old address
		req.addr <= ~addr;
		req.write <= ~wr;
	endtask
endmodule // imdec_master

/* File: dv/testbench.sv */
module testbench;
	timeunit 1ns;
	timeprecision 1ns;

	localparam logic [31:0] LB = 32'h1230_0000;

	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic base_wr = 1'b0;
	logic [15:0] base_wdata = 16'h0000;
	imdec_pkg::imdec_req_s req;
	imdec_pkg::imdec_resp_s resp;
	logic [15:0] internal_space_base;
	int fails = 0;
	int n_tests = 0;

	always #5 sys_clk = ~sys_clk;

	imdec_master imdec_master_inst (
		.sys_clk(sys_clk),
		.req(req)
	);

	imdec_decoder imdec_decoder_inst (
		.sys_clk(sys_clk),
		.rst(rst),
		.base_wr(base_wr),
		.base_wdata(base_wdata),
		.req(req),
		.resp(resp),
		.internal_space_base(internal_space_base)
	);

	task automatic end_of_test;
		$display("checks %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp) begin
			fails++;
			$display("wrong value %s expected %h seen %h", name, exp, got);
		end
	endtask

	// one decode, waiting a bounded time for the answer
	task automatic look(input logic [31:0] addr, input imdec_pkg::imdec_region_e rg,
		input logic [17:0] off, input logic [1:0] size = 2'b10, input logic err = 1'b0);
		int n;
		n = 0;
		imdec_master_inst.issue(addr, size, addr[2]);
		#1;
		while (resp.valid !== 1'b1 && n < 4) begin
			@(posedge sys_clk);
			#1;
			n++;
		end
		chk("resp.valid", 1'b1, resp.valid);
		chk("resp.hit", rg != imdec_pkg::RG_NONE, resp.hit);
		chk("resp.region", rg, resp.region);
		chk("resp.local_off", off, resp.local_off);
		chk("resp.write", addr[2], resp.write);
		chk("resp.size_err", err, resp.size_err);
	endtask

	task automatic load_base(input logic [15:0] v);
		@(posedge sys_clk);
		base_wr <= 1'b1;
		base_wdata <= v;
		@(posedge sys_clk);
		base_wr <= 1'b0;
		#1;
		chk("internal_space_base", v, internal_space_base);
	endtask

	task automatic reset_values;
		#1;
		chk("internal_space_base", imdec_pkg::BASE_RESET, internal_space_base);
		chk("resp.valid", 1'b0, resp.valid);
		load_base(16'h4320);
		@(posedge sys_clk);
		rst <= 1'b1;
		repeat (2) @(posedge sys_clk);
		rst <= 1'b0;
		@(posedge sys_clk);
		#1;
		chk("internal_space_base", imdec_pkg::BASE_RESET, internal_space_base);
	endtask

	task automatic legacy_map;
		load_base(16'h1230);
		look(LB + 32'h4, imdec_pkg::RG_SYS, 18'h4);
		look(LB + 32'ha00, imdec_pkg::RG_USB, 18'h0);
		look(LB + 32'ha20, imdec_pkg::RG_SER2, 18'h0);
		look(LB + 32'ha77, imdec_pkg::RG_SER3, 18'h37);
		look(LB + 32'hac8, imdec_pkg::RG_PORTE, 18'h0);
		look(LB + 32'hac4, imdec_pkg::RG_CPM, 18'h4c);
		look(LB + 32'he08, imdec_pkg::RG_ETH1, 18'h8);
		look(LB + 32'h1e08, imdec_pkg::RG_ETH2, 18'h8);
		look(LB + 32'h2fff, imdec_pkg::RG_DPRAM, 18'hfff);
		look(LB + 32'h3000, imdec_pkg::RG_DPRAMX, 18'h0);
		look(LB + 32'h3c00, imdec_pkg::RG_NONE, 18'h0);
		look(32'h5678_2004, imdec_pkg::RG_NONE, 18'h0);
		look(LB + 32'h2_0004, imdec_pkg::RG_NONE, 18'h0);
	endtask

	task automatic secure_map;
		load_base(16'h1232);
		look(LB + 32'h2004, imdec_pkg::RG_DPRAM, 18'h4);
		look(LB + 32'h2_0004, imdec_pkg::RG_SEC, 18'h4);
		look(LB + 32'h3_fffc, imdec_pkg::RG_SEC, 18'h1_fffc);
		look(LB + 32'h1_0000, imdec_pkg::RG_NONE, 18'h0);
		look(LB + 32'h4_0000, imdec_pkg::RG_NONE, 18'h0);
		look(LB + 32'h2_0006, imdec_pkg::RG_SEC, 18'h6, 2'b10, 1'b1);
		look(LB + 32'h2_0008, imdec_pkg::RG_SEC, 18'h8, 2'b01, 1'b1);
	endtask

	task automatic reserved_codes;
		for (int i = 0; i < 2; i++) begin
			logic [15:0] b;
			// legacy block sits at the whole 16-bit base, code bits included
			b = 16'h1231 | {14'h0000, i[0], 1'b0};
			load_base(b);
			look({b, 16'h2004}, imdec_pkg::RG_DPRAM, 18'h4);
			look(LB + 32'h2_0004, imdec_pkg::RG_NONE, 18'h0);
		end
	endtask

	initial begin
		repeat (2) @(posedge sys_clk);
		rst <= 1'b0;
		reset_values();
		legacy_map();
		secure_map();
		reserved_codes();
		end_of_test();
	end

	// the whole run needs well under a thousand cycles
	initial begin
		#100us;
		fails++;
		end_of_test();
	end
endmodule // testbench

/* File: pkg/imdec_pkg.sv */
package imdec_pkg;

	// ----------------------------------------
	// internal space base and layout selection
	// ----------------------------------------
	localparam logic [15:0] BASE_RESET = 16'hff00;
	localparam logic [1:0] LAYOUT_SECURE = 2'b10;
	localparam logic [1:0] SIZE_WORD = 2'b10;
	localparam int SPACE_LEGACY_BITS = 16;
	localparam int SPACE_WIDE_BITS = 18;

	// ----------------------------------------
	// region offsets inside the internal space
	// ----------------------------------------
	localparam logic [15:0] SYS_LO = 16'h0000;
	localparam logic [15:0] SYS_HI = 16'h09ff;
	localparam logic [15:0] USB_LO = 16'h0a00;
	localparam logic [15:0] USB_HI = 16'h0a1f;
	localparam logic [15:0] SER2_LO = 16'h0a20;
	localparam logic [15:0] SER2_HI = 16'h0a3f;
	localparam logic [15:0] SER3_LO = 16'h0a40;
	localparam logic [15:0] SER3_HI = 16'h0a77;
	localparam logic [15:0] PORTE_LO = 16'h0ac8;
	localparam logic [15:0] PORTE_HI = 16'h0adf;
	localparam logic [15:0] CPM_LO = 16'h0a78;
	localparam logic [15:0] CPM_HI = 16'h0dff;
	localparam logic [15:0] ETH1_LO = 16'h0e00;
	localparam logic [15:0] ETH1_HI = 16'h0fff;
	localparam logic [15:0] ETH2_LO = 16'h1e00;
	localparam logic [15:0] ETH2_HI = 16'h1fff;
	localparam logic [15:0] ETH2_SHIFT = 16'h1000;
	localparam logic [15:0] DPRAM_LO = 16'h2000;
	localparam logic [15:0] DPRAM_HI = 16'h2fff;
	localparam logic [15:0] DPRAMX_LO = 16'h3000;
	localparam logic [15:0] DPRAMX_HI = 16'h3bff;
	localparam logic [17:0] SEC_LO = 18'h2_0000;

	// ----------------------------------------
	// types
	// ----------------------------------------
	typedef enum logic [3:0] {
		RG_NONE, RG_SYS, RG_USB, RG_SER2, RG_SER3, RG_CPM, RG_PORTE,
		RG_ETH1, RG_ETH2, RG_DPRAM, RG_DPRAMX, RG_SEC
	} imdec_region_e;

	typedef struct packed {
		logic valid;
		logic [31:0] addr;
		logic write;
		logic [1:0] size;
	} imdec_req_s;

	typedef struct packed {
		logic valid;
		logic hit;
		imdec_region_e region;
		logic [17:0] local_off;
		logic write;
		logic size_err;
	} imdec_resp_s;

endpackage
